//--- pkg/bdec_params.svh
// constants for the byte-op instruction decoder
`ifndef BDEC_PARAMS_SVH
`define BDEC_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define BDEC_OFS_CTRL 8'h00
`define BDEC_OFS_STATUS 8'h04
`define BDEC_OFS_WORK 8'h08
`define BDEC_OFS_BANK 8'h0c
`define BDEC_OFS_PROD 8'h10
`define BDEC_OFS_PC 8'h14
// ----------------------------------------
// field positions
// ----------------------------------------
`define BDEC_CTRL_RUN 0
`define BDEC_CTRL_PSA 1
`define BDEC_ST_C 0
`define BDEC_ST_DC 1
`define BDEC_ST_Z 2
`define BDEC_ST_OV 3
`define BDEC_ST_N 4
// ----------------------------------------
// flag masks and reset values
// ----------------------------------------
`define BDEC_FL_ALL 5'h1f
`define BDEC_FL_ZN 5'h14
`define BDEC_FL_CZN 5'h15
`define BDEC_FL_Z 5'h04
`define BDEC_PC_RST 20'h00000
`define BDEC_CTRL_RST 2'h0
`define BDEC_SECOND_PFX 4'hf
`endif

//--- pkg/bdec_pkg.sv
// types for the byte-op instruction decoder
package bdec_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_PWAIT, ST_DECODE, ST_DWAIT, ST_EXEC}
    bdec_state_type;
  typedef enum logic [3:0] {ALU_ADD, ALU_AND, ALU_OR, ALU_XOR, ALU_RLC, ALU_RRC,
    ALU_RLN, ALU_RRN, ALU_SWAP} bdec_alu_op_type;
  typedef enum logic [1:0] {PEND_NONE, PEND_MOVE, PEND_JUMP, PEND_CALL} bdec_pend_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } bdec_apb_in_type;
  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] wdata;
  } bdec_dmem_req_type;
endpackage

//--- hw/bdec_alu.sv
// eight-bit alu of the byte-op decoder
module bdec_alu (
  input bdec_pkg::bdec_alu_op_type op,
  input logic [7:0] a,
  input logic [7:0] b,
  input logic cin,
  output logic [7:0] y,
  output logic c,
  output logic dc,
  output logic ov
);
  import bdec_pkg::*;
  // ----------------------------------------
  // adder with nibble carry
  // ----------------------------------------
  logic [8:0] sum;
  logic [4:0] half;
  assign sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  assign half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign dc = half[4];
  assign ov = (a[7] == b[7]) && (sum[7] != a[7]);
  // operation select
  always_comb begin
    y = a | b;
    c = cin;
    case (op)
      ALU_ADD: begin
        y = sum[7:0];
        c = sum[8];
      end
      ALU_AND: y = a & b;
      ALU_XOR: y = a ^ b;
      ALU_RLC: begin
        y = {a[6:0], cin};
        c = a[7];
      end
      ALU_RRC: begin
        y = {cin, a[7:1]};
        c = a[0];
      end
      ALU_RLN: y = {a[6:0], a[7]};
      ALU_RRN: y = {a[0], a[7:1]};
      ALU_SWAP: y = {a[3:0], a[7:4]};
      default: y = a | b;
    endcase
  end
endmodule

//--- hw/bdec_core.sv
// byte-op instruction decoder and execution control with apb access
// Summary of operation
// RULE1: byte op: opcode high, destination bit 9, bank bit 8, address 7..0
// RULE2: destination 0 writes working register, 1 writes the file register
// RULE3: bank bit 0 uses access bank, 1 uses bank select register
// RULE4: file move: two words, two cycles, 12-bit source then destination, no flags
// RULE5: bit op: bit number 11..9, bank bit 8, address 7..0
// RULE6: literal op: 8-bit immediate in low byte, opcode in high byte
// RULE7: jump and call target: low byte from word one, high bits from word two
// RULE8: call first word carries fast bit into call and return logic
// RULE9: fast bit set saves or restores shadows, clear leaves them alone
// RULE10: branch always uses 11-bit offset, conditional branches 8-bit offset
// RULE11: branch offsets are signed and added to the program counter
// RULE12: add and add with carry: one cycle, update C DC Z OV N
// RULE13: or, and, xor, complement: one cycle, update only Z and N
// RULE14: compare less, equal, greater skip on condition, no flag change
// RULE15: decrement then skip on zero or nonzero, flags unchanged
// RULE16: increment then skip on zero or nonzero, flags unchanged
// RULE17: rotates through carry update C, Z and N
// RULE18: rotates without carry update Z and N only
// RULE19: three subtracts update C DC Z OV N
// RULE20: multiply takes one cycle and changes no flag
// RULE21: multiply product goes to product high and low bytes
// RULE22: port read-modify-write uses pin levels, not latch contents (negate at the port still uses dmem_rdata)
// RULE23: writing the timer-zero register clears its prescaler if assigned
// RULE24: pc change or true skip costs a second nop cycle; two-word skip costs three
// RULE25: an unconsumed second word executes as a nop
// RULE26: banked address is bank select low nibble above the 8-bit address
//
// Register access over APB and the register offsets were decided locally.
`include "bdec_params.svh"
module bdec_core #(
  parameter logic [11:0] PORT_ADDR = 12'hf80,
  parameter logic [11:0] TIMER_ADDR = 12'hf90,
  parameter logic [7:0] ACCESS_SPLIT = 8'h80,
  parameter int STACK_DEPTH = 8
) (
  input logic pclk,
  input logic presetn,
  input bdec_pkg::bdec_apb_in_type apb_in,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [19:0] prog_addr,
  input logic [15:0] instr_word,
  output bdec_pkg::bdec_dmem_req_type dmem_req,
  input logic [7:0] dmem_rdata,
  input logic [7:0] port_pins,
  output logic prescaler_clear
);
  import bdec_pkg::*;
  localparam int SPW = $clog2(STACK_DEPTH);
  // ----------------------------------------
  // state
  // ----------------------------------------
  bdec_state_type state_reg;
  bdec_pend_type pend_reg;
  logic [19:0] pc_reg, prog_addr_reg;
  logic [15:0] ir_reg, prod_reg;
  logic [7:0] w_reg, lit_lo_reg, move_reg, sh_w_reg;
  logic [4:0] status_reg, sh_status_reg;
  logic [3:0] bsr_reg, sh_bsr_reg;
  logic [1:0] ctrl_reg;
  logic fast_reg, skip_reg, bubble_reg, second_reg, presc_reg;
  logic [SPW-1:0] sp_reg;
  logic [19:0] stack_reg [STACK_DEPTH];
  logic [7:0] pin_meta_reg, pin_sync_reg;
  bdec_dmem_req_type dmem_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg;
  // access bank folds low addresses to bank 0, high ones to the last bank
  function automatic logic [11:0] file_addr(input logic [15:0] w, input logic [3:0] bs);
    file_addr = w[8] ? {bs, w[7:0]} :  // [RULE3] [RULE26]
      ((w[7:0] < ACCESS_SPLIT) ? {4'h0, w[7:0]} : {4'hf, w[7:0]});
  endfunction
  // ----------------------------------------
  // fetch side decode
  // ----------------------------------------
  wire nop_slot = skip_reg | bubble_reg;
  wire [15:0] word = nop_slot ? 16'h0000 : instr_word;
  wire is_second = (pend_reg != PEND_NONE) && !nop_slot &&
    (instr_word[15:12] == `BDEC_SECOND_PFX);
  wire move_first = word[15:12] == 4'hc;
  wire [11:0] dec_addr = is_second ? instr_word[11:0] :  // [RULE4]
    (move_first ? word[11:0] : file_addr(word, bsr_reg));  // [RULE1] [RULE5]
  // ----------------------------------------
  // execute side decode
  // ----------------------------------------
  wire exec = state_reg == ST_EXEC;
  wire [7:0] k = ir_reg[7:0];  // [RULE6]
  wire has_d = (ir_reg[15:12] >= 4'h1 && ir_reg[15:12] <= 4'h5) ||
    (ir_reg[15:10] == 6'b000001);
  wire bit_mod = ir_reg[15:12] == 4'h7 || ir_reg[15:13] == 3'b100;
  wire port_rmw = (dmem_reg.addr == PORT_ADDR) && ((has_d && ir_reg[9]) || bit_mod);
  wire [7:0] fv = port_rmw ? pin_sync_reg : dmem_rdata;  // [RULE22]
  wire [7:0] bmask = 8'h01 << ir_reg[11:9];  // [RULE5]
  wire c_in = status_reg[`BDEC_ST_C];
  wire op_bra = ir_reg[15:11] == 5'b11010;
  wire op_bcond = ir_reg[15:11] == 5'b11100;
  wire op_call = ir_reg[15:9] == 7'b1110110;
  wire op_absolute_jump = ir_reg[15:8] == 8'hef;
  wire op_ret = ir_reg[15:1] == 15'h0009;
  wire op_movlb = ir_reg[15:4] == 12'h001;
  wire op_mul = ir_reg[15:9] == 7'b0000001;
  wire [1:0] fsel = ir_reg[10:9];
  wire flag_pick = fsel == 2'd0 ? status_reg[`BDEC_ST_Z] :
    fsel == 2'd1 ? status_reg[`BDEC_ST_C] :
    fsel == 2'd2 ? status_reg[`BDEC_ST_OV] : status_reg[`BDEC_ST_N];
  wire br_take = flag_pick ^ ir_reg[8];
  wire [19:0] off11 = {{9{ir_reg[10]}}, ir_reg[10:0]};  // [RULE10] [RULE11]
  wire [19:0] off8 = {{12{ir_reg[7]}}, ir_reg[7:0]};  // [RULE10] [RULE11]
  bdec_alu_op_type aop;
  logic [7:0] aa, ab, alu_y;
  logic acin, wr, dest_f, skip_t, alu_c, alu_dc, alu_ov;
  logic [4:0] fmask;
  // per-opcode alu setup, write-back and skip test
  always_comb begin
    aop = ALU_OR;
    aa = fv;
    ab = 8'h00;
    acin = 1'b0;
    fmask = 5'h00;
    wr = 1'b0;
    dest_f = ir_reg[9];  // [RULE2]
    skip_t = 1'b0;
    casez (ir_reg[15:8])
      8'b0010_00??, 8'b0010_01??: begin
        aop = ALU_ADD;
        ab = w_reg;
        acin = ir_reg[10] ? 1'b0 : c_in;
        fmask = `BDEC_FL_ALL;  // [RULE12]
        wr = 1'b1;
      end
      8'b0001_????: begin
        aop = ir_reg[11:10] == 2'd0 ? ALU_OR : ir_reg[11:10] == 2'd1 ? ALU_AND : ALU_XOR;
        ab = ir_reg[11:10] == 2'd3 ? 8'hff : w_reg;
        fmask = `BDEC_FL_ZN;  // [RULE13]
        wr = 1'b1;
      end
      8'b0110_000?, 8'b0110_001?, 8'b0110_010?: begin
        aop = ALU_ADD;
        ab = ~w_reg;
        acin = 1'b1;
        skip_t = ir_reg[10:9] == 2'd0 ? !alu_c :  // [RULE14]
          ir_reg[10:9] == 2'd1 ? alu_y == 8'h00 : alu_c && alu_y != 8'h00;
      end
      8'b0000_01??, 8'b0010_11??, 8'b0100_11??: begin
        aop = ALU_ADD;
        ab = 8'hff;
        wr = 1'b1;
        fmask = ir_reg[15:12] == 4'h0 ? `BDEC_FL_ALL : 5'h00;  // [RULE15]
        skip_t = ir_reg[14] ? alu_y != 8'h00 : ir_reg[13] && alu_y == 8'h00;  // [RULE15]
      end
      8'b0010_10??, 8'b0011_11??, 8'b0100_10??: begin
        aop = ALU_ADD;
        acin = 1'b1;
        wr = 1'b1;
        fmask = ir_reg[13:12] == 2'd2 ? `BDEC_FL_ALL : 5'h00;  // [RULE16]
        skip_t = ir_reg[14] ? alu_y != 8'h00 : ir_reg[12] && alu_y == 8'h00;  // [RULE16]
      end
      8'b0011_00??, 8'b0011_01??: begin
        aop = ir_reg[10] ? ALU_RLC : ALU_RRC;
        acin = c_in;
        fmask = `BDEC_FL_CZN;  // [RULE17]
        wr = 1'b1;
      end
      8'b0100_00??, 8'b0100_01??: begin
        aop = ir_reg[10] ? ALU_RLN : ALU_RRN;
        fmask = `BDEC_FL_ZN;  // [RULE18]
        wr = 1'b1;
      end
      8'b0101_00??: begin
        fmask = `BDEC_FL_ZN;
        wr = 1'b1;
      end
      8'b0101_01??, 8'b0101_10??, 8'b0101_11??: begin
        aop = ALU_ADD;
        aa = ir_reg[11:10] == 2'd1 ? w_reg : fv;
        ab = ir_reg[11:10] == 2'd1 ? ~fv : ~w_reg;
        acin = ir_reg[11:10] == 2'd3 ? 1'b1 : c_in;
        fmask = `BDEC_FL_ALL;  // [RULE19]
        wr = 1'b1;
      end
      8'b0011_10??: begin
        aop = ALU_SWAP;
        wr = 1'b1;
      end
      8'b0110_011?: skip_t = fv == 8'h00;
      8'b0110_1???: begin
        dest_f = 1'b1;
        wr = 1'b1;
        aop = ir_reg[10:9] == 2'd1 ? ALU_AND : ALU_OR;
        aa = ir_reg[10:9] == 2'd2 ? ~fv : (ir_reg[10:9] == 2'd3 ? 8'h00 : fv);
        ab = ir_reg[10:9] == 2'd0 ? 8'hff : (ir_reg[10:9] == 2'd3 ? w_reg : 8'h00);
        if (ir_reg[10:9] == 2'd2) begin
          aop = ALU_ADD;
          acin = 1'b1;
          fmask = `BDEC_FL_ALL;
        end
        if (ir_reg[10:9] == 2'd1) fmask = `BDEC_FL_Z;
      end
      8'b0111_????, 8'b1000_????, 8'b1001_????: begin
        dest_f = 1'b1;
        wr = 1'b1;
        aop = ir_reg[15] ? (ir_reg[12] ? ALU_AND : ALU_OR) : ALU_XOR;
        ab = ir_reg[12] ? ~bmask : bmask;
      end
      8'b1010_????, 8'b1011_????: skip_t = ((fv & bmask) == 8'h00) == ir_reg[12];
      8'h0e: begin
        aa = k;  // [RULE6]
        dest_f = 1'b0;
        wr = 1'b1;
      end
      default: wr = 1'b0;
    endcase
  end
  bdec_alu u_alu (
    .op(aop),
    .a(aa),
    .b(ab),
    .cin(acin),
    .y(alu_y),
    .c(alu_c),
    .dc(alu_dc),
    .ov(alu_ov)
  );
  wire [4:0] fnew = {alu_y[7], alu_ov, alu_y == 8'h00, alu_dc, alu_c};
  wire alu_exec = exec && !second_reg && wr;
  wire file_wr = alu_exec && dest_f;
  wire move_wr = exec && second_reg && pend_reg == PEND_MOVE;
  // ----------------------------------------
  // apb slave, one wait state
  // ----------------------------------------
  wire apb_acc = apb_in.psel && apb_in.penable;
  wire apb_wr = apb_acc && pready_reg && apb_in.pwrite;
  wire idle = state_reg == ST_IDLE;
  wire [7:0] pa = apb_in.paddr;
  wire hit = pa == `BDEC_OFS_CTRL || pa == `BDEC_OFS_STATUS || pa == `BDEC_OFS_WORK ||
    pa == `BDEC_OFS_BANK || pa == `BDEC_OFS_PROD || pa == `BDEC_OFS_PC;
  wire [31:0] rd_val = pa == `BDEC_OFS_CTRL ? {30'h0, ctrl_reg} :
    pa == `BDEC_OFS_STATUS ? {27'h0, status_reg} :
    pa == `BDEC_OFS_WORK ? {24'h0, w_reg} :
    pa == `BDEC_OFS_BANK ? {28'h0, bsr_reg} :
    pa == `BDEC_OFS_PROD ? {16'h0, prod_reg} :
    pa == `BDEC_OFS_PC ? {12'h0, pc_reg} : 32'h0;
  // bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= apb_acc && !pready_reg;
      if (apb_acc && !pready_reg) begin
        prdata_reg <= rd_val;
        pslverr_reg <= !hit;
      end
    end
  end
  // pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= 8'h00;
      pin_sync_reg <= 8'h00;
    end else begin
      pin_meta_reg <= port_pins;
      pin_sync_reg <= pin_meta_reg;
    end
  end
  // ----------------------------------------
  // sequencer and architectural registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      pend_reg <= PEND_NONE;
      pc_reg <= `BDEC_PC_RST;
      prog_addr_reg <= `BDEC_PC_RST;
      ir_reg <= 16'h0000;
      prod_reg <= 16'h0000;
      w_reg <= 8'h00;
      lit_lo_reg <= 8'h00;
      move_reg <= 8'h00;
      sh_w_reg <= 8'h00;
      status_reg <= 5'h00;
      sh_status_reg <= 5'h00;
      bsr_reg <= 4'h0;
      sh_bsr_reg <= 4'h0;
      ctrl_reg <= `BDEC_CTRL_RST;
      fast_reg <= 1'b0;
      skip_reg <= 1'b0;
      bubble_reg <= 1'b0;
      second_reg <= 1'b0;
      presc_reg <= 1'b0;
      sp_reg <= '0;
      dmem_reg <= '0;
    end else begin
      dmem_reg.we <= 1'b0;
      presc_reg <= 1'b0;
      if (apb_wr && pa == `BDEC_OFS_CTRL) ctrl_reg <= apb_in.pwdata[1:0];
      if (apb_wr && idle && pa == `BDEC_OFS_STATUS) status_reg <= apb_in.pwdata[4:0];
      if (apb_wr && idle && pa == `BDEC_OFS_WORK) w_reg <= apb_in.pwdata[7:0];
      if (apb_wr && idle && pa == `BDEC_OFS_BANK) bsr_reg <= apb_in.pwdata[3:0];
      case (state_reg)
        ST_IDLE: if (ctrl_reg[`BDEC_CTRL_RUN]) state_reg <= ST_FETCH;
        ST_FETCH: begin
          prog_addr_reg <= pc_reg;
          state_reg <= ST_PWAIT;
        end
        ST_PWAIT: state_reg <= ST_DECODE;
        ST_DECODE: begin
          ir_reg <= word;  // [RULE24]
          second_reg <= is_second;
          if (!is_second) pend_reg <= PEND_NONE;  // [RULE25]
          if (!bubble_reg) pc_reg <= pc_reg + 20'h1;
          skip_reg <= 1'b0;
          bubble_reg <= 1'b0;
          dmem_reg.addr <= dec_addr;
          state_reg <= ST_DWAIT;
        end
        ST_DWAIT: state_reg <= ST_EXEC;
        ST_EXEC: begin
          state_reg <= ctrl_reg[`BDEC_CTRL_RUN] ? ST_FETCH : ST_IDLE;
          if (second_reg) begin
            pend_reg <= PEND_NONE;
            if (pend_reg == PEND_MOVE) begin
              dmem_reg.we <= 1'b1;  // [RULE4]
              dmem_reg.wdata <= move_reg;
            end
            if (pend_reg != PEND_MOVE) pc_reg <= {ir_reg[11:0], lit_lo_reg};  // [RULE7]
            if (pend_reg == PEND_CALL) begin
              stack_reg[sp_reg] <= pc_reg;
              sp_reg <= sp_reg + 1'b1;
            end
            if (pend_reg == PEND_CALL && fast_reg) begin
              sh_w_reg <= w_reg;  // [RULE9]
              sh_status_reg <= status_reg;
              sh_bsr_reg <= bsr_reg;
            end
          end else begin
            if (ir_reg[15:12] == 4'hc) begin
              move_reg <= dmem_rdata;
              pend_reg <= PEND_MOVE;
            end
            if (op_absolute_jump || op_call) begin
              lit_lo_reg <= k;  // [RULE7]
              fast_reg <= op_call && ir_reg[8];  // [RULE8]
              pend_reg <= op_absolute_jump ? PEND_JUMP : PEND_CALL;
            end
            if (op_bra || (op_bcond && br_take)) begin
              pc_reg <= pc_reg + (op_bra ? off11 : off8);  // [RULE10] [RULE11]
              bubble_reg <= 1'b1;  // [RULE24]
            end
            if (op_ret) begin
              pc_reg <= stack_reg[sp_reg - 1'b1];
              sp_reg <= sp_reg - 1'b1;
              bubble_reg <= 1'b1;
            end
            if (op_ret && ir_reg[0]) begin
              w_reg <= sh_w_reg;  // [RULE9]
              status_reg <= sh_status_reg;
              bsr_reg <= sh_bsr_reg;
            end
            if (op_movlb) bsr_reg <= ir_reg[3:0];
            if (op_mul) prod_reg <= {8'h00, fv} * {8'h00, w_reg};  // [RULE20] [RULE21]
            if (wr) begin
              status_reg <= (status_reg & ~fmask) | (fnew & fmask);
              if (dest_f) begin
                dmem_reg.we <= 1'b1;  // [RULE2]
                dmem_reg.wdata <= alu_y;
              end else begin
                w_reg <= alu_y;  // [RULE2]
              end
            end
            skip_reg <= skip_t;  // [RULE24]
          end
          if ((file_wr || move_wr) && dmem_reg.addr == TIMER_ADDR)
            presc_reg <= ctrl_reg[`BDEC_CTRL_PSA];  // [RULE23]
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  // output drive
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prog_addr = prog_addr_reg;
  assign dmem_req = dmem_reg;
  assign prescaler_clear = presc_reg;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_exec_op;
    exec && !second_reg;
  endsequence
  // a taken branch leaves three slots with the bubble flag up, the last one being the next decode
  sequence s_bubble_slots;
    bubble_reg [*3];
  endsequence
  a_skip_nop_slot: assert property ( // [RULE24]
    (state_reg == ST_DECODE && skip_reg) |=> ir_reg == 16'h0)
    else $error("skipped slot did not run as nop");
  a_bubble_hold_pc: assert property ( // [RULE24]
    (state_reg == ST_DECODE && bubble_reg) |=> $stable(pc_reg))
    else $error("bubble advanced the pc");
  a_dest_work: assert property ( // [RULE2]
    (alu_exec && !dest_f) |=> w_reg == $past(alu_y) && !dmem_reg.we)
    else $error("result missed working register");
  a_dest_file: assert property ( // [RULE2]
    (alu_exec && dest_f) |=> dmem_reg.we && dmem_reg.wdata == $past(alu_y))
    else $error("result missed file register");
  a_bank_addr: assert property ( // [RULE26]
    (state_reg == ST_DECODE && !is_second && !move_first && word[8])
    |=> dmem_reg.addr == {$past(bsr_reg), $past(word[7:0])})
    else $error("banked address wrong");
  a_mul_product: assert property ((s_exec_op and op_mul) // [RULE21]
    |=> prod_reg == $past(fv) * $past(w_reg) && $stable(status_reg))
    else $error("product or flags wrong after multiply");
  a_logic_flags: assert property ((s_exec_op and ir_reg[15:12] == 4'h1) // [RULE13]
    |=> status_reg[3] == $past(status_reg[3]) && status_reg[1:0] == $past(status_reg[1:0]))
    else $error("logic op touched arithmetic flags");
  a_timer_clear: assert property ( // [RULE23]
    (file_wr && dmem_reg.addr == TIMER_ADDR && ctrl_reg[1])
    |=> prescaler_clear ##1 !prescaler_clear)
    else $error("prescaler clear missing");
  a_port_pins: assert property ((exec && port_rmw) |-> fv == $past(port_pins, 2)) // [RULE22]
    else $error("port rmw did not use pins");
  a_branch_target: assert property ((s_exec_op and op_bra) // [RULE11]
    |=> pc_reg == $past(pc_reg) + $past(off11) ##0 s_bubble_slots)
    else $error("branch target or bubble wrong");
  a_move_flags: assert property ((exec && second_reg && pend_reg == PEND_MOVE) // [RULE4]
    |=> $stable(status_reg) && dmem_reg.we && dmem_reg.wdata == $past(move_reg))
    else $error("file move wrong");
endmodule

//--- verification/bdec_prog_mem.sv
// program memory model that feeds instruction words to the decoder
module bdec_prog_mem (
  input wire logic pclk,
  input wire logic [19:0] prog_addr,
  output logic [15:0] instr_word,
  input wire logic load_en,
  input wire logic [7:0] load_addr,
  input wire logic [15:0] load_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [256];
  // ----------------------------------------
  // storage
  // ----------------------------------------
  // unloaded words read as nop
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // registered read, one clock of latency, as the core expects
  always @(posedge pclk) begin
    if (load_en) mem[load_addr] <= load_data;
    instr_word <= mem[prog_addr[7:0]];
  end
endmodule

//--- verification/byte_op_instruction_decoder_test.sv
// self-checking bench: program rows run on the core, writes and registers checked
module byte_op_instruction_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import bdec_pkg::*;
  typedef struct packed {logic [15:0] word; logic wr; logic [11:0] addr; logic [7:0] data;}
    bdec_row_type;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  bdec_apb_in_type apb_in = '0;
  logic [31:0] prdata;
  logic pready, pslverr, prescaler_clear;
  logic [19:0] prog_addr;
  logic [15:0] instr_word;
  bdec_dmem_req_type dmem_req;
  logic [7:0] dmem_rdata = 8'h00;
  logic [7:0] port_pins = 8'h30;
  logic load_en = 1'b0;
  logic [7:0] load_addr = 8'h00;
  logic [15:0] load_data = 16'h0000;
  logic [7:0] dmem [4096];
  logic [19:0] log_q [$];
  int mismatches = 0, total_checks = 0, cycles = 0, clears = 0;
  logic [31:0] rd;
  logic err;
  // ----------------------------------------
  // program rows: word, write expected, address, data
  // ----------------------------------------
  bdec_row_type rows [26] = '{
    '{16'h2610, 1'b1, 12'h010, 8'h0f}, '{16'h1611, 1'b1, 12'h011, 8'h04},
    '{16'h4612, 1'b1, 12'h012, 8'h03}, '{16'h1b20, 1'b1, 12'h320, 8'hfa},
    '{16'hc010, 1'b1, 12'h030, 8'h0f}, '{16'hf030, 1'b0, 12'h000, 8'h00},
    '{16'h2e13, 1'b1, 12'h013, 8'h00}, '{16'h2614, 1'b0, 12'h000, 8'h00},
    '{16'h0215, 1'b0, 12'h000, 8'h00}, '{16'h2690, 1'b1, 12'hf90, 8'h00},
    '{16'h1280, 1'b1, 12'hf80, 8'h35}, '{16'h6216, 1'b0, 12'h000, 8'h00},
    '{16'h2614, 1'b0, 12'h000, 8'h00}, '{16'h3617, 1'b1, 12'h017, 8'h01},
    '{16'h5e18, 1'b1, 12'h018, 8'h02}, '{16'h3e19, 1'b1, 12'h019, 8'h00},
    '{16'hc010, 1'b0, 12'h000, 8'h00}, '{16'hf031, 1'b0, 12'h000, 8'h00},
    '{16'h8c1a, 1'b1, 12'h01a, 8'h40}, '{16'h0e77, 1'b0, 12'h000, 8'h00},
    '{16'hef17, 1'b0, 12'h000, 8'h00}, '{16'hf000, 1'b0, 12'h000, 8'h00},
    '{16'h2614, 1'b0, 12'h000, 8'h00}, '{16'he201, 1'b0, 12'h000, 8'h00},
    '{16'h2614, 1'b0, 12'h000, 8'h00}, '{16'hd7ff, 1'b0, 12'h000, 8'h00}};
  always #4 pclk = ~pclk;
  bdec_core uut (.pclk(pclk), .presetn(presetn), .apb_in(apb_in), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr), .instr_word(instr_word),
    .dmem_req(dmem_req), .dmem_rdata(dmem_rdata), .port_pins(port_pins),
    .prescaler_clear(prescaler_clear));
  bdec_prog_mem prog (.pclk(pclk), .prog_addr(prog_addr), .instr_word(instr_word),
    .load_en(load_en), .load_addr(load_addr), .load_data(load_data));
  // ----------------------------------------
  // data memory, write log and timeout
  // ----------------------------------------
  always @(posedge pclk) begin
    cycles++;
    if (dmem_req.we === 1'b1) begin
      dmem[dmem_req.addr] <= dmem_req.wdata;
      log_q.push_back({dmem_req.addr, dmem_req.wdata});
    end
    dmem_rdata <= dmem[dmem_req.addr];
    if (prescaler_clear === 1'b1) clears++;
    if (cycles == 4000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one apb transfer: setup, access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    apb_in <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    apb_in.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_in <= '0;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    foreach (dmem[i]) dmem[i] = 8'h00;
    dmem[12'h010] = 8'h0a;
    dmem[12'h011] = 8'h0c;
    dmem[12'h012] = 8'h81;
    dmem[12'h320] = 8'hff;
    dmem[12'h013] = 8'h01;
    dmem[12'h015] = 8'h03;
    dmem[12'hf90] = 8'hfb;
    dmem[12'h016] = 8'h05;
    dmem[12'h017] = 8'h80;
    dmem[12'h018] = 8'h07;
    dmem[12'h019] = 8'hff;
    repeat (12) @(posedge pclk);
    chk("reset prog_addr", 32'h0, {12'h000, prog_addr});
    chk("reset clear", 32'h0, {31'h0, prescaler_clear});
    presetn <= 1'b1;
    foreach (rows[i]) begin
      @(posedge pclk);
      load_en <= 1'b1;
      load_addr <= 8'(i);
      load_data <= rows[i].word;
    end
    @(posedge pclk);
    load_en <= 1'b0;
    apb(1'b1, 8'h08, 32'h5);
    apb(1'b1, 8'h0c, 32'h3);
    apb(1'b1, 8'h10, 32'hffff);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, 8'h00, 32'h3);
    while (log_q.size() < 12) @(posedge pclk);
    repeat (40) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h2);
    foreach (rows[i]) begin
      if (rows[i].wr) chk("file write", {12'h000, rows[i].addr, rows[i].data},
        {12'h000, log_q.pop_front()});
    end
    chk("extra writes", 32'h0, 32'(log_q.size()));
    chk("prescaler clears", 32'h1, 32'(clears));
    apb(1'b0, 8'h04, 32'h0);
    chk("status", 32'h03, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("product", 32'h000f, rd);
    apb(1'b0, 8'h08, 32'h0);
    chk("working", 32'h77, rd);
    test_done();
  end
endmodule
